// ### rtl/multi_station_capture.v
// Multi-station edge capture with AXI4-Lite register and memory access
//
// Overview of operation
// [R1] Clamp station and object counts to 1..32
// [R2] Filter count 0..32767, negative becomes zero
// [R3] Filter count zero disables filtering
// [R4] Seven 16-bit configuration words, counts low first
// [R5] Parameters: references, entering errors, leaving errors
// [R6] Parameter area overflow refuses the operation
// [R7] Zero reference makes station inactive
// [R8] Heads, tails, then per-object entering/leaving values
// [R9] Result overflow writes only fitting entries silently
// [R10] Levels shorter than filter count are dropped
// [R11] Qualified edge: sample, advance head, store sum
// [R12] ON goes to entering, OFF to leaving
// [R13] Both edge kinds advance the head
// [R14] Head cycles one to twice objects
// [R15] Head zero means nothing entered yet
// [R16] Head meeting tail reverts, result still stored
// [R17] Initially low: rising odd, falling even
// [R18] Initially high: falling odd, rising even
// [R19] Start clears no stored values or indices
// [R20] Only one operation instance at a time
// [R21] Running enables edge interrupt, suspends others
// [R22] Position source is 32-bit accumulating counter
// [R23] Sums wrap modulo two to the 32
// [R24] Trigger synchronised by two registers
`timescale 1ns/1ps
`include "msc_defs.vh"
module multi_station_capture (
  input wire CORE_CLK_I,
  input wire SRST_I,
  input wire [31:0] POSITION_COUNT_I,
  input wire FAST_TRIGGER_A_I,
  input wire FAST_TRIGGER_B_I,
  output wire TRIG_EDGE_IRQ_EN_O,
  output wire OTHER_IRQ_SUSPEND_O,
  input wire [12:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [12:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I
);
  // States
  localparam ST_IDLE = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_STEP = 2'b10;

  // Storage
  reg [31:0] param_mem [0:`MSC_PARAM_WORDS-1]; // References and errors
  reg [15:0] head_mem [0:`MSC_MAX_ST-1]; // Head indices
  reg [15:0] tail_mem [0:`MSC_MAX_ST-1]; // Tail indices
  reg [31:0] cmp_mem [0:`MSC_RES_WORDS-1]; // Compare values

  // Configuration and control
  reg [15:0] cfg_stations; // Raw station count
  reg [15:0] cfg_objects; // Raw object count
  reg [15:0] cfg_filter; // Raw signed filter count
  reg [31:0] rise_count; // Qualified rising edges
  reg [31:0] fall_count; // Qualified falling edges
  reg ctrl_run; // Operation enable
  reg ctrl_sel; // Trigger input select
  reg [6:0] param_base; // First parameter word index
  reg refused; // Last start refused
  reg init_level; // Trigger level at start

  // Operation state
  reg [1:0] state;
  reg [5:0] n_act; // Clamped station count
  reg [5:0] m_act; // Clamped object count
  reg [14:0] filt_act; // Effective filter count
  reg [4:0] sidx; // Station being processed
  reg [31:0] cnt_snap; // Sampled counter
  reg pend; // Edge waiting during a pass
  reg run_q; // Previous run bit

  // Filter interface
  // Synchroniser lags the select: change input two cycles before a start
  wire trig_sel = ctrl_sel ? FAST_TRIGGER_B_I : FAST_TRIGGER_A_I;
  wire filt_level;
  wire edge_rise;
  wire edge_fall;
  wire raw_level;
  wire start_now = ctrl_run & ~run_q & (state == ST_IDLE);

  trigger_edge_filter u_filter (
    .clk_i(CORE_CLK_I),
    .rst_i(SRST_I),
    .trig_i(trig_sel),
    .load_i(state == ST_IDLE),
    .filt_count_i(filt_act),
    .level_o(filt_level),
    .rise_o(edge_rise),
    .fall_o(edge_fall),
    .raw_level_o(raw_level)
  );

  wire edge_any = (edge_rise | edge_fall) & (state != ST_IDLE); // R13

  // Clamp helper for counts
  function [5:0] clamp32;
    input [15:0] v;
    begin
      if ($signed(v) < $signed(`MSC_LIM_MIN))
        clamp32 = 6'h01; // R1
      else if ($signed(v) > $signed(`MSC_LIM_MAX))
        clamp32 = 6'h20; // R1
      else
        clamp32 = v[5:0];
    end
  endfunction

  wire [5:0] n_start = clamp32(cfg_stations);
  wire [15:0] filt_start = cfg_filter[15] ? 16'h0000 : cfg_filter; // R2
  wire [7:0] param_end = {1'b0, param_base} + {2'h0, n_start} + {2'h0, n_start} + {2'h0, n_start};
  wire param_fits = param_end <= 8'h80; // R6

  // Per-station computation
  wire [15:0] head_cur = head_mem[sidx];
  wire [15:0] two_m = {9'h000, m_act, 1'b0};
  wire [15:0] head_att = (head_cur >= two_m) ? 16'h0001 : head_cur + 16'h0001; // R14
  wire head_keep = (head_att == tail_mem[sidx]); // R16
  wire [6:0] p_ref = param_base + {2'h0, sidx};
  wire [6:0] p_in = p_ref + {1'b0, n_act};
  wire [6:0] p_out = p_in + {1'b0, n_act};
  wire [31:0] ref_val = param_mem[p_ref]; // R5
  wire station_on = (ref_val != 32'h00000000); // R7
  wire [31:0] err_val = head_att[0] ? param_mem[p_in] : param_mem[p_out]; // R12
  wire [31:0] cmp_val = cnt_snap + ref_val + err_val; // R23
  wire [11:0] cmp_idx = ((head_att[11:0] - 12'h001) * {6'h00, n_act}) + {7'h00, sidx}; // R8
  wire cmp_fits = cmp_idx < 12'h400; // R9
  wire step_wr = (state == ST_STEP) & station_on;

  // Capture side owns the storage in these cycles
  wire cap_busy = (state == ST_STEP) | edge_any | start_now;

  // Write channel: both address and data taken together
  wire wr_go = AWVALID_I & WVALID_I & ~BVALID_O & ~cap_busy;
  assign AWREADY_O = wr_go;
  assign WREADY_O = wr_go;
  assign ARREADY_O = ~RVALID_O;

  assign TRIG_EDGE_IRQ_EN_O = (state != ST_IDLE); // R21
  assign OTHER_IRQ_SUSPEND_O = (state != ST_IDLE); // R21

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // Write address decode
  wire aw_cfg = (AWADDR_I < 13'h002C) && (AWADDR_I[1:0] == 2'b00) && (AWADDR_I != 13'h001C); // Hole at 0x1C
  wire aw_param = (AWADDR_I >= `MSC_PARAM_WIN) && (AWADDR_I < `MSC_HEAD_WIN);
  wire aw_head = (AWADDR_I >= `MSC_HEAD_WIN) && (AWADDR_I < `MSC_TAIL_WIN);
  wire aw_tail = (AWADDR_I >= `MSC_TAIL_WIN) && (AWADDR_I < 13'h0700);
  wire aw_ok = aw_cfg | aw_param | aw_head | aw_tail;
  wire [31:0] w16 = merge(32'h00000000, WDATA_I, WSTRB_I);
  wire [31:0] head_merge = merge({16'h0000, head_mem[AWADDR_I[6:2]]}, WDATA_I, WSTRB_I); // Low half kept
  wire [31:0] tail_merge = merge({16'h0000, tail_mem[AWADDR_I[6:2]]}, WDATA_I, WSTRB_I); // Low half kept

  // Memory writes: capture first, bus otherwise
  always @(posedge CORE_CLK_I) begin
    if (step_wr) begin
      head_mem[sidx] <= head_keep ? head_cur : head_att; // R11 R16
      if (cmp_fits)
        cmp_mem[cmp_idx[9:0]] <= cmp_val; // R9 R11
    end else if (wr_go) begin
      if (aw_param)
        param_mem[AWADDR_I[8:2]] <= merge(param_mem[AWADDR_I[8:2]], WDATA_I, WSTRB_I);
      if (aw_head)
        head_mem[AWADDR_I[6:2]] <= head_merge[15:0];
      if (aw_tail)
        tail_mem[AWADDR_I[6:2]] <= tail_merge[15:0];
    end
  end

  // Configuration registers and edge counters
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      cfg_stations <= `MSC_RST_CFG;
      cfg_objects <= `MSC_RST_CFG;
      cfg_filter <= `MSC_RST_FILT;
      rise_count <= 32'h00000000;
      fall_count <= 32'h00000000;
      ctrl_run <= 1'b0;
      ctrl_sel <= 1'b0;
      param_base <= 7'h00;
    end else if (edge_any) begin
      // Counting wins over bus writes
      if (edge_rise)
        rise_count <= rise_count + 32'h00000001; // R4
      if (edge_fall)
        fall_count <= fall_count + 32'h00000001; // R4
    end else if (wr_go) begin
      case (AWADDR_I)
        `MSC_CFG_STATIONS: cfg_stations <= w16[15:0]; // R4
        `MSC_CFG_OBJECTS: cfg_objects <= w16[15:0]; // R4
        `MSC_CFG_FILTER: cfg_filter <= w16[15:0]; // R4
        `MSC_CFG_RISE_LO: rise_count[15:0] <= w16[15:0];
        `MSC_CFG_RISE_HI: rise_count[31:16] <= w16[15:0];
        `MSC_CFG_FALL_LO: fall_count[15:0] <= w16[15:0];
        `MSC_CFG_FALL_HI: fall_count[31:16] <= w16[15:0];
        `MSC_CTRL: begin
          if (WSTRB_I[0]) begin
            ctrl_run <= WDATA_I[`MSC_CTRL_RUN];
            ctrl_sel <= WDATA_I[`MSC_CTRL_SEL];
          end
        end
        `MSC_PARAM_BASE: begin
          if (WSTRB_I[0])
            param_base <= WDATA_I[6:0];
        end
        default: begin
          // Read-only or unmapped
        end
      endcase
    end
  end

  // Write response
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= `MSC_RESP_OKAY;
    end else if (wr_go) begin
      BVALID_O <= 1'b1;
      BRESP_O <= aw_ok ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // Read data multiplexer
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (ARADDR_I >= `MSC_CMP_WIN)
      rd_mux = cmp_mem[ARADDR_I[11:2]];
    else if (ARADDR_I >= `MSC_PARAM_WIN && ARADDR_I < `MSC_HEAD_WIN)
      rd_mux = param_mem[ARADDR_I[8:2]];
    else if (ARADDR_I >= `MSC_HEAD_WIN && ARADDR_I < `MSC_TAIL_WIN)
      rd_mux = {16'h0000, head_mem[ARADDR_I[6:2]]}; // R15
    else if (ARADDR_I >= `MSC_TAIL_WIN && ARADDR_I < 13'h0700)
      rd_mux = {16'h0000, tail_mem[ARADDR_I[6:2]]};
    else begin
      case (ARADDR_I)
        `MSC_CFG_STATIONS: rd_mux = {16'h0000, cfg_stations};
        `MSC_CFG_OBJECTS: rd_mux = {16'h0000, cfg_objects};
        `MSC_CFG_FILTER: rd_mux = {16'h0000, cfg_filter};
        `MSC_CFG_RISE_LO: rd_mux = {16'h0000, rise_count[15:0]};
        `MSC_CFG_RISE_HI: rd_mux = {16'h0000, rise_count[31:16]};
        `MSC_CFG_FALL_LO: rd_mux = {16'h0000, fall_count[15:0]};
        `MSC_CFG_FALL_HI: rd_mux = {16'h0000, fall_count[31:16]};
        `MSC_CTRL: rd_mux = {30'h00000000, ctrl_sel, ctrl_run};
        `MSC_STATUS: rd_mux = {28'h0000000, pend, init_level, refused, state != ST_IDLE};
        `MSC_PARAM_BASE: rd_mux = {25'h0000000, param_base};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Read channel
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `MSC_RESP_OKAY;
    end else if (ARVALID_I && !RVALID_O) begin
      RVALID_O <= 1'b1;
      RDATA_O <= rd_mux;
      RRESP_O <= rd_ok ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // Capture sequencer
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state <= ST_IDLE;
      n_act <= 6'h01;
      m_act <= 6'h01;
      filt_act <= 15'h0000;
      sidx <= 5'h00;
      cnt_snap <= 32'h00000000;
      pend <= 1'b0;
      run_q <= 1'b0;
      refused <= 1'b0;
      init_level <= 1'b0;
    end else begin
      run_q <= ctrl_run;
      case (state)
        ST_IDLE: begin
          pend <= 1'b0;
          if (start_now) begin
            // Start keeps all stored values and indices
            refused <= ~param_fits; // R6 R19
            init_level <= raw_level; // R17 R18
            n_act <= n_start; // R1
            m_act <= clamp32(cfg_objects); // R1
            filt_act <= filt_start[14:0]; // R2
            if (param_fits)
              state <= ST_ARMED; // R20
          end
        end
        ST_ARMED: begin
          if (edge_any) begin
            // Sample the accumulating counter
            cnt_snap <= POSITION_COUNT_I; // R11 R22
            sidx <= 5'h00;
            state <= ST_STEP;
          end else if (!ctrl_run) begin
            state <= ST_IDLE;
          end
        end
        ST_STEP: begin
          if (edge_any)
            pend <= 1'b1;
          if ({1'b0, sidx} == n_act - 6'h01) begin
            if (pend || edge_any) begin
              // Serve the edge caught during the pass
              cnt_snap <= POSITION_COUNT_I; // R11
              sidx <= 5'h00;
              pend <= pend & edge_any; // New edge stays pending
            end else begin
              state <= ST_ARMED;
            end
          end else begin
            sidx <= sidx + 5'h01; // R11
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // multi_station_capture

// ### rtl/msc_defs.vh
// Constants for the multi-station edge capture block
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
// Bus geometry
`define MSC_ADDR_W 13
// Configuration block word offsets (byte addresses)
`define MSC_CFG_STATIONS 13'h0000
`define MSC_CFG_OBJECTS 13'h0004
`define MSC_CFG_FILTER 13'h0008
`define MSC_CFG_RISE_LO 13'h000C
`define MSC_CFG_RISE_HI 13'h0010
`define MSC_CFG_FALL_LO 13'h0014
`define MSC_CFG_FALL_HI 13'h0018
// Control, status and parameter base
`define MSC_CTRL 13'h0020
`define MSC_STATUS 13'h0024
`define MSC_PARAM_BASE 13'h0028
// Control fields
`define MSC_CTRL_RUN 0
`define MSC_CTRL_SEL 1
// Status fields
`define MSC_ST_RUNNING 0
`define MSC_ST_REFUSED 1
`define MSC_ST_INIT_LVL 2
`define MSC_ST_PENDING 3
// Memory windows (byte addresses)
`define MSC_PARAM_WIN 13'h0400
`define MSC_HEAD_WIN 13'h0600
`define MSC_TAIL_WIN 13'h0680
`define MSC_CMP_WIN 13'h1000
// Storage sizes in words
`define MSC_PARAM_WORDS 128
`define MSC_RES_WORDS 1024
`define MSC_MAX_ST 32
// Clamp limits
`define MSC_LIM_MIN 16'h0001
`define MSC_LIM_MAX 16'h0020
// Reset values
`define MSC_RST_CFG 16'h0001
`define MSC_RST_FILT 16'h0000
// Bus responses
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2
`endif

// ### rtl/trigger_edge_filter.v
// Trigger synchroniser and edge qualification filter
`timescale 1ns/1ps
module trigger_edge_filter (
  input wire clk_i,
  input wire rst_i,
  input wire trig_i,
  input wire load_i,
  input wire [14:0] filt_count_i,
  output reg level_o,
  output reg rise_o,
  output reg fall_o,
  output wire raw_level_o
);
  reg sync_a; // First synchroniser stage
  reg sync_b; // Second synchroniser stage
  reg [14:0] run_len; // Samples of differing level so far

  assign raw_level_o = sync_b;

  // Two-stage synchroniser
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= trig_i; // R24
      sync_b <= sync_a; // R24
    end
  end

  // Filter: new level must persist for the programmed count
  always @(posedge clk_i) begin
    rise_o <= 1'b0;
    fall_o <= 1'b0;
    if (rst_i) begin
      level_o <= 1'b0;
      run_len <= 15'h0000;
    end else if (load_i) begin
      // Adopt present level without an edge
      level_o <= sync_b;
      run_len <= 15'h0000;
    end else if (sync_b == level_o) begin
      // Short pulse dropped
      run_len <= 15'h0000; // R10
    end else if (filt_count_i == 15'h0000 || run_len + 15'h0001 >= filt_count_i) begin
      // Zero count accepts at once
      level_o <= sync_b; // R3
      run_len <= 15'h0000;
      rise_o <= sync_b;
      fall_o <= ~sync_b;
    end else begin
      run_len <= run_len + 15'h0001; // R10
    end
  end
endmodule // trigger_edge_filter

// ### tb/trigger_encoder_model.sv
// Trigger sensor and accumulating position counter model
`timescale 1ns/1ps
module trigger_encoder_model (
  input wire clk_i,
  output logic trig_a_o,
  output logic trig_b_o,
  output logic [31:0] count_o
);
  // Sensors idle low, counter at zero
  initial begin
    trig_a_o = 1'b0;
    trig_b_o = 1'b0;
    count_o = 32'h0;
  end
  // Advance counter, set one sensor, hold
  task automatic drive(input logic sel, input logic lvl, input logic [31:0] delta, input int hold);
    @(posedge clk_i);
    count_o <= count_o + delta;
    if (sel) begin
      trig_b_o <= lvl;
    end else begin
      trig_a_o <= lvl;
    end
    repeat (hold) @(posedge clk_i);
  endtask
endmodule // trigger_encoder_model

// ### tb/multi_station_capture_asserts.sv
// Port checks for the capture block
`timescale 1ns/1ps
module multi_station_capture_asserts (
  input wire CORE_CLK_I,
  input wire SRST_I,
  input wire AWVALID_I,
  input wire AWREADY_O,
  input wire WVALID_I,
  input wire WREADY_O,
  input wire [1:0] BRESP_O,
  input wire BVALID_O,
  input wire BREADY_I,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire [31:0] RDATA_O,
  input wire [1:0] RRESP_O,
  input wire RVALID_O,
  input wire RREADY_I,
  input wire TRIG_EDGE_IRQ_EN_O,
  input wire OTHER_IRQ_SUSPEND_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // Request accepted on each channel
  sequence s_wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence s_rd_taken;
    ARVALID_I && ARREADY_O;
  endsequence
  wr_answer_a: assert property (s_wr_taken |=> BVALID_O)
    else $error("write not answered next cycle");
  rd_answer_a: assert property (s_rd_taken |=> RVALID_O)
    else $error("read not answered next cycle");
  wr_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped early");
  rd_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
    else $error("read data dropped early");
  rd_release_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read data not released");
  ar_ready_a: assert property (ARREADY_O == !RVALID_O)
    else $error("read address ready wrong");
  b_cause_a: assert property ($rose(BVALID_O) |-> $past(AWVALID_I && WVALID_I))
    else $error("write response without request");
  irq_pair_a: assert property (TRIG_EDGE_IRQ_EN_O == OTHER_IRQ_SUSPEND_O)
    else $error("interrupt enable and suspend differ");
  reset_quiet_a: assert property ($fell(SRST_I) |-> !BVALID_O && !RVALID_O && !TRIG_EDGE_IRQ_EN_O)
    else $error("outputs active after reset");
endmodule // multi_station_capture_asserts

// ### tb/multi_station_edge_capture_test.sv
// Self-checking bench for the capture block
`timescale 1ns/1ps
`include "msc_defs.vh"
module multi_station_edge_capture_test;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic [12:0] awaddr, araddr;
  logic [31:0] wdata, seed, pos, c1, c2;
  wire awready, wready, bvalid, arready, rvalid, irq_en, irq_sus, trig_a, trig_b;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, count;
  int num_errors = 0;
  int total_checks = 0;
  logic [34:0] rq[$]; // Expected {care, resp, data}
  logic [1:0] bq[$]; // Expected write responses
  logic [34:0] e;
  trigger_encoder_model model (.clk_i(clk), .trig_a_o(trig_a), .trig_b_o(trig_b), .count_o(count));
  multi_station_capture uut (.CORE_CLK_I(clk), .SRST_I(srst), .POSITION_COUNT_I(count),
    .FAST_TRIGGER_A_I(trig_a), .FAST_TRIGGER_B_I(trig_b), .TRIG_EDGE_IRQ_EN_O(irq_en),
    .OTHER_IRQ_SUSPEND_O(irq_sus), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tally_and_finish;
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare each bus answer with the oldest note
  always @(posedge clk) begin
    if (bvalid && bready) begin
      total_checks++;
      if (bresp !== bq.pop_front()) begin
        num_errors++;
        $display("ERROR %0t write response mismatch", $time);
      end
    end
    if (rvalid && rready) begin
      e = rq.pop_front();
      total_checks++;
      if (rresp !== e[33:32] || (e[34] && rdata !== e[31:0])) begin
        num_errors++;
        $display("ERROR %0t read mismatch addr %h", $time, araddr);
      end
    end
  end
  // Bus write, channels released independently
  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] r = `MSC_RESP_OKAY);
    logic a_ok, w_ok, b_ok;
    a_ok = 0;
    w_ok = 0;
    b_ok = 0;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge clk);
      if (awready && !a_ok) begin
        a_ok = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) b_ok = 1;
    end
    bready <= 1'b0;
  endtask
  // Bus read; care low checks response only
  task automatic rd(input logic [12:0] a, input logic [31:0] d, input logic [1:0] r = `MSC_RESP_OKAY,
                    input logic c = 1'b1);
    logic a_ok, r_ok;
    a_ok = 0;
    r_ok = 0;
    rq.push_back({c, r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(posedge clk);
      if (arready && !a_ok) begin
        a_ok = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) r_ok = 1;
    end
    rready <= 1'b0;
  endtask
  // Interrupt enable and suspend follow the running state
  task automatic chk_irq(input logic x);
    total_checks++;
    if (irq_en !== x || irq_sus !== x) begin
      num_errors++;
      $display("ERROR %0t interrupt outputs %b %b", $time, irq_en, irq_sus);
    end
  endtask
  // Qualified edge with a fresh counter step
  task automatic step(input logic sel, input logic lvl);
    seed = lfsr(seed);
    pos = pos + seed;
    model.drive(sel, lvl, seed, 16);
  endtask
  // Runs far longer than the whole sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    awaddr = 13'h0;
    araddr = 13'h0;
    wdata = 32'h0;
    seed = 32'h3322;
    pos = 32'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(`MSC_CFG_STATIONS, 32'h1);
    rd(`MSC_CFG_OBJECTS, 32'h1);
    rd(`MSC_CFG_FILTER, 32'h0);
    rd(13'h001C, 32'h0, `MSC_RESP_SLVERR, 1'b0);
    wr(13'h001C, 32'h0, `MSC_RESP_SLVERR);
    wr(`MSC_CFG_STATIONS, 32'd33);
    wr(`MSC_PARAM_BASE, 32'd32);
    wr(`MSC_CTRL, 32'h1);
    rd(`MSC_STATUS, 32'h1);
    chk_irq(1'b1);
    wr(`MSC_CTRL, 32'h0);
    wr(`MSC_CFG_STATIONS, 32'd32);
    chk_irq(1'b0);
    wr(`MSC_PARAM_BASE, 32'd33);
    wr(`MSC_CTRL, 32'h1);
    rd(`MSC_STATUS, 32'h2);
    chk_irq(1'b0);
    wr(`MSC_CTRL, 32'h0);
    wr(`MSC_PARAM_BASE, 32'h0);
    wr(`MSC_CFG_STATIONS, 32'h2);
    wr(`MSC_CFG_OBJECTS, 32'h2);
    wr(`MSC_CFG_FILTER, 32'h8000);
    wr(`MSC_PARAM_WIN, 32'h200);
    wr(`MSC_PARAM_WIN + 13'h4, 32'h0);
    wr(`MSC_PARAM_WIN + 13'h8, 32'd100);
    wr(`MSC_PARAM_WIN + 13'h10, 32'hFFFFFFEC);
    wr(`MSC_HEAD_WIN, 32'h0);
    wr(`MSC_TAIL_WIN, 32'h2);
    wr(`MSC_CTRL, 32'h1);
    rd(`MSC_STATUS, 32'h1);
    seed = lfsr(seed);
    pos = pos + (32'hFFFFFE00 | seed[7:0]);
    model.drive(1'b0, 1'b1, 32'hFFFFFE00 | seed[7:0], 16);
    c1 = pos;
    step(1'b0, 1'b0);
    rd(`MSC_HEAD_WIN, 32'h1);
    rd(`MSC_CMP_WIN, c1 + 32'h264);
    rd(`MSC_CMP_WIN + 13'h8, pos + 32'h1EC);
    rd(`MSC_CFG_RISE_LO, 32'h1);
    rd(`MSC_CFG_FALL_LO, 32'h1);
    wr(`MSC_CTRL, 32'h0);
    wr(`MSC_CFG_OBJECTS, 32'h1);
    wr(`MSC_CFG_FILTER, 32'h4);
    wr(`MSC_HEAD_WIN, 32'h2);
    wr(`MSC_TAIL_WIN, 32'h0);
    model.drive(1'b1, 1'b1, 32'h0, 8);
    wr(`MSC_CTRL, 32'h2);
    wr(`MSC_CTRL, 32'h3);
    rd(`MSC_STATUS, 32'h5);
    chk_irq(1'b1);
    rd(`MSC_HEAD_WIN, 32'h2);
    model.drive(1'b1, 1'b0, 32'h0, 2);
    model.drive(1'b1, 1'b1, 32'h0, 12);
    rd(`MSC_CFG_FALL_LO, 32'h1);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    c2 = pos;
    step(1'b1, 1'b0);
    rd(`MSC_HEAD_WIN, 32'h1);
    rd(`MSC_CMP_WIN, pos + 32'h264);
    rd(`MSC_CMP_WIN + 13'h8, c2 + 32'h1EC);
    rd(`MSC_CFG_FALL_LO, 32'h3);
    tally_and_finish;
  end
endmodule // multi_station_edge_capture_test
bind multi_station_capture multi_station_capture_asserts chk (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .TRIG_EDGE_IRQ_EN_O(TRIG_EDGE_IRQ_EN_O), .OTHER_IRQ_SUSPEND_O(OTHER_IRQ_SUSPEND_O));
